// *** verilog/csw_defs.svh ***
/*
 * Constants of the cyclic sense and wake timer block: register offsets,
 * field positions, reset values and timing figures.
 * Assumes a 250 MHz system clock and an 8-bit register address.
 */
`ifndef CSW_DEFS_SVH
`define CSW_DEFS_SVH

// clock and timing
`define CSW_CLK_MHZ 250
`define CSW_TICK_NS 100000
`define CSW_FILT_NS 16000
`define CSW_FILT_CYC ((`CSW_FILT_NS * `CSW_CLK_MHZ + 999) / 1000)

// register offsets
`define CSW_OFS_TMR_A 8'h00
`define CSW_OFS_TMR_B 8'h04
`define CSW_OFS_HS 8'h08
`define CSW_OFS_WKC 8'h0C
`define CSW_OFS_STA 8'h10
`define CSW_OFS_STB 8'h14
`define CSW_OFS_LVL 8'h18
`define CSW_OFS_MODE 8'h1C

// field positions
`define CSW_TMR_PER_LSB 0
`define CSW_TMR_ON_LSB 4
`define CSW_WKC_TMR_LSB 0
`define CSW_WKC_SNS_LSB 2
`define CSW_WKC_SEL_LSB 5
`define CSW_STA_TMR_LSB 3
`define CSW_STB_SPI_BIT 0
`define CSW_STB_HS_LSB 1

// reset value of every control register
`define CSW_RST_REG 8'h00

// mode request codes
`define CSW_REQ_NORMAL 2'h0
`define CSW_REQ_STOP 2'h1
`define CSW_REQ_SLEEP 2'h2

// period lengths in 0.1 ms ticks
`define CSW_PER_10MS 15'h0064
`define CSW_PER_20MS 15'h00C8
`define CSW_PER_50MS 15'h01F4
`define CSW_PER_100MS 15'h03E8
`define CSW_PER_200MS 15'h07D0
`define CSW_PER_1S 15'h2710
`define CSW_PER_2S 15'h4E20

// on-time lengths in 0.1 ms ticks
`define CSW_ON_0P1MS 15'h0001
`define CSW_ON_0P3MS 15'h0003
`define CSW_ON_1MS 15'h000A
`define CSW_ON_10MS 15'h0064
`define CSW_ON_20MS 15'h00C8

`endif

// *** verilog/csw_pkg.sv ***
/*
 * Types and decode functions of the cyclic sense and wake timer block.
 * Assumes csw_defs.svh is on the include path.
 */
package csw_pkg;
`include "csw_defs.svh"

	typedef enum logic [2:0] {
		CSW_NORMAL,
		CSW_STOP,
		CSW_SLEEP,
		CSW_RESTART,
		CSW_FAILSAFE
	} csw_mode_t;

	typedef struct packed {
		logic run;
		logic [14:0] cnt;
		logic on;
		logic on_end;
		logic wake;
	} csw_tmr_st_t;

	typedef struct packed {
		csw_mode_t mode;
		logic [15:0] tdiv;
		logic tick;
		logic [7:0] tmr_a;
		logic [7:0] tmr_b;
		logic [7:0] hs_ctrl;
		logic [7:0] wk_ctrl;
		logic [4:0] sta;
		logic [3:0] stb;
		logic [2:0] lvl;
		logic [1:0] ld;
		logic [2:0] fbusy;
		logic [2:0] fbad;
		logic [2:0] fval;
		logic [2:0] refv;
		logic [2:0] ref_lvl;
		logic [2:0][11:0] fcnt;
		logic [2:0] hs;
		logic int_b;
		logic rst_b;
		logic [15:0] rdata;
	} csw_st_t;

	function automatic logic [14:0] csw_per_ticks(input logic [2:0] sel);
		case (sel)
			3'h0: return `CSW_PER_10MS;
			3'h1: return `CSW_PER_20MS;
			3'h2: return `CSW_PER_50MS;
			3'h3: return `CSW_PER_100MS;
			3'h4: return `CSW_PER_200MS;
			3'h5: return `CSW_PER_1S;
			default: return `CSW_PER_2S;
		endcase
	endfunction : csw_per_ticks

	function automatic logic [14:0] csw_on_ticks(input logic [2:0] sel);
		case (sel)
			3'h1: return `CSW_ON_0P1MS;
			3'h2: return `CSW_ON_0P3MS;
			3'h3: return `CSW_ON_1MS;
			3'h4: return `CSW_ON_10MS;
			3'h5: return `CSW_ON_20MS;
			default: return 15'h0000;
		endcase
	endfunction : csw_on_ticks

	// codes 1..5 run the timer, 0 idles low, 6 and 7 idle high
	function automatic logic csw_on_run(input logic [2:0] sel);
		return sel >= 3'h1 && sel <= 3'h5;
	endfunction : csw_on_run

endpackage : csw_pkg

// *** verilog/csw_timer.sv ***
/*
 * One periodic timer: period and on-time counted in 0.1 ms ticks.
 * Assumes tick_in is a one-cycle enable and load_in follows a write of
 * the settings, which are stable from that cycle on.
 */
`timescale 1ns/1ps
module csw_timer (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// time base and settings
	input wire logic tick_in,
	input wire logic load_in,
	input wire logic [2:0] per_sel_in,
	input wire logic [2:0] on_sel_in,
	// timer state
	output logic on_out,
	output logic on_end_out,
	output logic wake_out,
	output logic run_out
);
	import csw_pkg::*;

	csw_tmr_st_t s;
	csw_tmr_st_t n;
	logic [14:0] per_t;
	logic [14:0] on_t;

	assign per_t = csw_per_ticks(per_sel_in);
	assign on_t = csw_on_ticks(on_sel_in);

	always_comb
	begin
		n = s;
		n.on_end = 1'b0;
		n.wake = 1'b0;
		if (load_in)
		begin
			// writing an on-time starts at once, without a wake pulse
			n.run = csw_on_run(on_sel_in);
			n.cnt = 15'h0000;
			n.on = csw_on_run(on_sel_in) || on_sel_in[2:1] == 2'b11;
		end
		else if (s.run && tick_in)
		begin
			n.cnt = s.cnt + 15'h0001;
			if (s.cnt == on_t - 15'h0001)
			begin
				n.on = 1'b0;
				n.on_end = 1'b1;
			end
			if (s.cnt == per_t - 15'h0001)
			begin
				n.cnt = 15'h0000;
				n.on = 1'b1;
				n.wake = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			s <= '0;
		else
			s <= n;
	end

	assign on_out = s.on;
	assign on_end_out = s.on_end;
	assign wake_out = s.wake;
	assign run_out = s.run;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);

	tmr_first_wake_a: assert property (load_in |=> !wake_out ##1 !wake_out)
		else $error("timer woke on its first on-time");
	tmr_period_a: assert property (wake_out |-> run_out && on_out &&
		s.cnt == 15'h0000)
		else $error("timer wake without a new on-time");

endmodule : csw_timer

// *** verilog/csw_top.sv ***
/*
 * Cyclic sense and cyclic wake: two timers pulse the high-side switches,
 * wake inputs are sampled after each on-time through a 16 us filter, and
 * level changes set wake flags, raise the interrupt or leave sleep.
 * Assumes all inputs are synchronous to clk_in and one bus master.
 */
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "csw_defs.svh"
module csw_top #(
	parameter int unsigned TICK_CYC = (`CSW_TICK_NS * `CSW_CLK_MHZ) / 1000
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// register port
	input wire logic [7:0] addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [15:0] rdata_out,
	// wake pins and switch faults
	input wire logic [2:0] wake_pin_in,
	input wire logic [2:0] hs_fault_in,
	input wire logic fail_safe_in,
	// switches, interrupt, mode
	output logic [2:0] highside_switch_out,
	output logic int_b_out,
	output logic reset_b_out,
	output csw_pkg::csw_mode_t mode_out
);
	import csw_pkg::*;

	localparam logic [11:0] FILT_LAST = 12'(`CSW_FILT_CYC - 1);
	localparam logic [15:0] TICK_LAST = 16'(TICK_CYC - 1);

	csw_st_t s;
	csw_st_t n;
	logic a_on;
	logic a_end;
	logic a_wake;
	logic b_on;
	logic b_end;
	logic b_wake;
	logic [2:0] pin_ev;
	logic [2:0] cyc_v;
	logic [1:0] tw;
	logic awake;

	// timers run on regardless of switch faults
	csw_timer u_tmr_a (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.tick_in(s.tick),
		.load_in(s.ld[0]),
		.per_sel_in(s.tmr_a[`CSW_TMR_PER_LSB +: 3]),
		.on_sel_in(s.tmr_a[`CSW_TMR_ON_LSB +: 3]),
		.on_out(a_on),
		.on_end_out(a_end),
		.wake_out(a_wake),
		.run_out()
	);

	csw_timer u_tmr_b (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.tick_in(s.tick),
		.load_in(s.ld[1]),
		.per_sel_in(s.tmr_b[`CSW_TMR_PER_LSB +: 3]),
		.on_sel_in(s.tmr_b[`CSW_TMR_ON_LSB +: 3]),
		.on_out(b_on),
		.on_end_out(b_end),
		.wake_out(b_wake),
		.run_out()
	);

	// too long on-time for the period
	function automatic logic bad_timing(input logic [7:0] v);
		logic [2:0] on_s;
		on_s = v[`CSW_TMR_ON_LSB +: 3];
		return csw_on_run(on_s) && csw_on_ticks(on_s) >
			csw_per_ticks(v[`CSW_TMR_PER_LSB +: 3]);
	endfunction : bad_timing

	always_comb
	begin
		logic ends;
		logic hsv;
		logic [4:0] clr_a;
		logic [3:0] clr_b;
		logic spi_bad;
		spi_bad = 1'b0;
		ends = 1'b0;
		hsv = 1'b0;
		clr_a = 5'h00;
		clr_b = 4'h0;
		n = s;
		pin_ev = 3'h0;
		cyc_v = 3'h0;
		n.ld = 2'h0;
		awake = s.mode == CSW_NORMAL || s.mode == CSW_STOP;

		// 0.1 ms time base
		n.tick = s.tdiv == TICK_LAST;
		n.tdiv = n.tick ? 16'h0000 : s.tdiv + 16'h0001;

		// register writes
		if (wr_in)
		begin
			case (addr_in)
				`CSW_OFS_TMR_A:
				begin
					n.tmr_a = wdata_in[7:0];
					n.ld[0] = 1'b1;
				end
				`CSW_OFS_TMR_B:
				begin
					n.tmr_b = wdata_in[7:0];
					n.ld[1] = 1'b1;
				end
				`CSW_OFS_HS: n.hs_ctrl = wdata_in[7:0];
				`CSW_OFS_WKC: n.wk_ctrl = wdata_in[7:0];
				`CSW_OFS_STA: clr_a = wdata_in[4:0];
				`CSW_OFS_STB: clr_b = wdata_in[3:0];
				default: ;
			endcase
		end
		if (wr_in && (addr_in == `CSW_OFS_TMR_A ||
			addr_in == `CSW_OFS_TMR_B) && bad_timing(wdata_in[7:0]))
			spi_bad = 1'b1;

		// wake pin sensing
		for (int i = 0; i < 3; i++)
		begin
			cyc_v[i] = s.wk_ctrl[`CSW_WKC_SNS_LSB + i] &&
				s.mode != CSW_FAILSAFE;
			ends = s.wk_ctrl[`CSW_WKC_SEL_LSB + i] ? b_end : a_end;
			if (cyc_v[i])
			begin
				if (ends)
				begin
					n.fbusy[i] = 1'b1;
					n.fbad[i] = 1'b0;
					n.fcnt[i] = 12'h000;
					n.fval[i] = wake_pin_in[i];
				end
				else if (s.fbusy[i])
				begin
					if (wake_pin_in[i] != s.fval[i])
						n.fbad[i] = 1'b1;
					if (s.fcnt[i] == FILT_LAST)
					begin
						n.fbusy[i] = 1'b0;
						if (!s.fbad[i] && wake_pin_in[i] == s.fval[i])
						begin
							n.lvl[i] = s.fval[i];
							n.ref_lvl[i] = s.fval[i];
							n.refv[i] = 1'b1;
							pin_ev[i] = s.refv[i] &&
								s.fval[i] != s.ref_lvl[i];
						end
					end
					else
						n.fcnt[i] = s.fcnt[i] + 12'h001;
				end
			end
			else
			begin
				// static sense: level must differ for the filter time
				n.fbusy[i] = 1'b0;
				n.refv[i] = 1'b0;
				if (wake_pin_in[i] == s.lvl[i])
					n.fcnt[i] = 12'h000;
				else if (s.fcnt[i] == FILT_LAST)
				begin
					n.lvl[i] = wake_pin_in[i];
					n.fcnt[i] = 12'h000;
					pin_ev[i] = 1'b1;
				end
				else
					n.fcnt[i] = s.fcnt[i] + 12'h001;
			end
		end

		// cyclic wake from the timers
		tw[0] = a_wake && s.wk_ctrl[`CSW_WKC_TMR_LSB] && awake;
		tw[1] = b_wake && s.wk_ctrl[`CSW_WKC_TMR_LSB + 1] && awake;

		// flags: a new event beats a clear in the same cycle
		n.sta = (s.sta & ~clr_a) | {tw, pin_ev};
		n.stb = (s.stb & ~clr_b) |
			{(s.mode != CSW_FAILSAFE && s.mode != CSW_RESTART) ?
			hs_fault_in : 3'h0, spi_bad};
		n.int_b = !(awake && (|pin_ev || |tw));

		// mode sequencing
		case (s.mode)
			CSW_NORMAL, CSW_STOP:
			begin
				if (wr_in && addr_in == `CSW_OFS_MODE)
				begin
					case (wdata_in[1:0])
						`CSW_REQ_NORMAL: n.mode = CSW_NORMAL;
						`CSW_REQ_STOP: n.mode = CSW_STOP;
						`CSW_REQ_SLEEP:
							n.mode = |s.sta ? CSW_RESTART
								: CSW_SLEEP;
						default: ;
					endcase
				end
			end
			CSW_SLEEP:
				if (|pin_ev || |s.sta)
					n.mode = CSW_RESTART;
			CSW_RESTART: n.mode = CSW_NORMAL;
			CSW_FAILSAFE:
				if (!fail_safe_in && |pin_ev)
					n.mode = CSW_RESTART;
			default: n.mode = CSW_NORMAL;
		endcase
		if (fail_safe_in)
			n.mode = CSW_FAILSAFE;
		n.rst_b = n.mode != CSW_RESTART;

		// switch drive: forced, or following a timer
		for (int i = 0; i < 3; i++)
		begin
			case (s.hs_ctrl[2 * i +: 2])
				2'h0: hsv = 1'b0;
				2'h1: hsv = 1'b1;
				2'h2: hsv = a_on;
				default: hsv = b_on;
			endcase
			n.hs[i] = hsv && s.mode != CSW_FAILSAFE &&
				!s.stb[`CSW_STB_HS_LSB + i];
		end

		// read data stands in the cycle after the strobe
		n.rdata = 16'h0000;
		if (rd_in)
		begin
			case (addr_in)
				`CSW_OFS_TMR_A: n.rdata = {8'h00, s.tmr_a};
				`CSW_OFS_TMR_B: n.rdata = {8'h00, s.tmr_b};
				`CSW_OFS_HS: n.rdata = {8'h00, s.hs_ctrl};
				`CSW_OFS_WKC: n.rdata = {8'h00, s.wk_ctrl};
				`CSW_OFS_STA: n.rdata = {11'h000, s.sta};
				`CSW_OFS_STB: n.rdata = {12'h000, s.stb};
				`CSW_OFS_LVL: n.rdata = {13'h0000, s.lvl};
				`CSW_OFS_MODE: n.rdata = {13'h0000, s.mode};
				default: n.rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			s <= '0;
			s.mode <= CSW_NORMAL;
			s.tmr_a <= `CSW_RST_REG;
			s.tmr_b <= `CSW_RST_REG;
			s.hs_ctrl <= `CSW_RST_REG;
			s.wk_ctrl <= `CSW_RST_REG;
			s.int_b <= 1'b1;
			s.rst_b <= 1'b1;
		end
		else
			s <= n;
	end

	assign rdata_out = s.rdata;
	assign highside_switch_out = s.hs;
	assign int_b_out = s.int_b;
	assign reset_b_out = s.rst_b;
	assign mode_out = s.mode;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);

	sequence restart_seq;
		s.mode == CSW_RESTART && !reset_b_out ##1 s.mode == CSW_NORMAL;
	endsequence

	sleep_wake_a: assert property (s.mode == CSW_SLEEP && |pin_ev &&
		!fail_safe_in ##1 !fail_safe_in |-> restart_seq)
		else $error("sense wake did not leave sleep");
	stop_int_a: assert property (s.mode == CSW_STOP && |pin_ev
		|=> !int_b_out ##1 int_b_out)
		else $error("sense wake in stop gave no interrupt");
	sleep_flag_a: assert property (wr_in && addr_in == `CSW_OFS_MODE &&
		wdata_in[1:0] == `CSW_REQ_SLEEP && awake && |s.sta &&
		!fail_safe_in ##1 !fail_safe_in |-> restart_seq)
		else $error("sleep entered with a wake flag set");
	pin_flag_a: assert property (pin_ev[0] |=> s.sta[0])
		else $error("wake pin flag not set");
	fault_off_a: assert property (hs_fault_in[1] && s.mode == CSW_STOP
		|=> ##1 !highside_switch_out[1])
		else $error("faulty switch still on");
	failsafe_off_a: assert property (s.mode == CSW_FAILSAFE
		|=> highside_switch_out == 3'h0)
		else $error("switch on in fail-safe");
	timing_fail_a: assert property (wr_in && addr_in == `CSW_OFS_TMR_A &&
		bad_timing(wdata_in[7:0]) |=> s.stb[`CSW_STB_SPI_BIT])
		else $error("interface failure flag not set");
	filter_len_a: assert property (pin_ev[0] && cyc_v[0]
		|-> s.fcnt[0] == FILT_LAST && $stable(wake_pin_in[0]))
		else $error("sense wake before the filter time");
	level_hold_a: assert property (cyc_v[2] && !pin_ev[2] && !s.fbusy[2]
		|=> $stable(s.lvl[2]))
		else $error("level state changed outside a sample");

endmodule : csw_top

// *** testbench/csw_partner.sv ***
/*
 * Far-side model: one switch network per wake pin, fed by its high-side
 * switch, with a hold capacitor and a pull-down on the pin.
 * Assumes the bench sets closed_in and the device drives hs_in.
 */
`timescale 1ns/1ps
module csw_partner #(
	parameter int HOLD_CYC = 5000
) (
	// clock
	input wire logic clk_in,
	// switch supply and contact state
	input wire logic [2:0] hs_in,
	input wire logic [2:0] closed_in,
	// wake pin levels
	output logic [2:0] pin_out = 3'h0
);
	logic [2:0][12:0] hold = '0;

	always_ff @(posedge clk_in)
	begin
		for (int i = 0; i < 3; i++)
		begin
			if (hs_in[i])
			begin
				pin_out[i] <= closed_in[i];
				hold[i] <= 13'h0000;
			end
			else if (hold[i] < 13'(HOLD_CYC))
				hold[i] <= hold[i] + 13'h0001;
			else
				pin_out[i] <= 1'b0; // held charge gone, pull-down wins
		end
	end
endmodule : csw_partner

// *** testbench/cyclic_sense_wake_timers_bench.sv ***
/*
 * Self-checking bench of csw_top with the switch network model.
 * Assumes TICK_CYC of 100, so 10 ms is 10000 cycles, filter 4000.
 */
`timescale 1ns/1ps
module cyclic_sense_wake_timers_bench;
	import csw_pkg::*;
	logic clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic [7:0] addr_in = 8'h00;
	logic [15:0] wdata_in = 16'h0000;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic [15:0] rdata_out;
	logic [2:0] wake_pin_in;
	logic [2:0] hs_fault_in = 3'h0;
	logic fail_safe_in = 1'b0;
	logic [2:0] highside_switch_out;
	logic int_b_out;
	logic reset_b_out;
	csw_mode_t mode_out;
	logic [2:0] closed = 3'h0;
	int failures = 0;
	int tests_run = 0;
	int int_cnt = 0;

	always #2 clk_in = ~clk_in;
	always @(posedge clk_in)
		if (int_b_out === 1'b0)
			int_cnt <= int_cnt + 1;

	csw_top #(.TICK_CYC(100)) u_dut (.clk_in(clk_in), .rst_b_in(rst_b_in),
		.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.rdata_out(rdata_out), .wake_pin_in(wake_pin_in),
		.hs_fault_in(hs_fault_in), .fail_safe_in(fail_safe_in),
		.highside_switch_out(highside_switch_out), .int_b_out(int_b_out),
		.reset_b_out(reset_b_out), .mode_out(mode_out));
	csw_partner u_net (.clk_in(clk_in), .hs_in(highside_switch_out),
		.closed_in(closed), .pin_out(wake_pin_in));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
	endtask : cyc

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask : wr

	task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1;
		chk(rdata_out, exp);
	endtask : rd_chk

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : give_verdict

	// all registers zero after reset, unmapped address reads zero
	task automatic t_reset;
		for (int a = 0; a <= 8'h20; a += 4)
			rd_chk(8'(a), 16'h0000);
	endtask : t_reset

	// timer wake in stop mode while switch 0 sits in a fault
	task automatic t_cyclic_wake;
		int n0;
		wr(8'h00, 16'h0000);
		wr(8'h0C, 16'h0001);
		wr(8'h08, 16'h0002);
		wr(8'h1C, 16'h0001);
		n0 = int_cnt;
		wr(8'h00, 16'h0010);
		cyc(20);
		hs_fault_in <= 3'h1;
		cyc(20);
		chk({13'h0000, highside_switch_out}, 16'h0000);
		chk({13'h0000, mode_out}, {13'h0000, CSW_STOP});
		cyc(24960);
		chk(16'(int_cnt - n0), 16'h0002);
		rd_chk(8'h10, 16'h0008);
		rd_chk(8'h14, 16'h0002);
		hs_fault_in <= 3'h0;
		wr(8'h00, 16'h0000);
		wr(8'h0C, 16'h0000);
		wr(8'h14, 16'h000E);
		wr(8'h10, 16'h0018);
		wr(8'h1C, 16'h0000);
		rd_chk(8'h1C, 16'h0000);
	endtask : t_cyclic_wake

	// sensed level change on pin 0, then sleep with the flag still set
	task automatic t_cyclic_sense;
		int n0;
		int seen;
		seen = 0;
		wr(8'h08, 16'h0002);
		wr(8'h0C, 16'h0004);
		n0 = int_cnt;
		wr(8'h00, 16'h0010);
		cyc(5000);
		chk(16'(int_cnt - n0), 16'h0000);
		closed <= 3'h1;
		cyc(12000);
		chk(16'(int_cnt - n0), 16'h0001);
		rd_chk(8'h10, 16'h0001);
		chk({13'h0000, wake_pin_in}, 16'h0000);
		rd_chk(8'h18, 16'h0001);
		wr(8'h00, 16'h0000);
		wr(8'h1C, 16'h0002);
		for (int i = 0; i < 10; i++)
		begin
			#1;
			if (reset_b_out === 1'b0)
				seen = 1;
			@(posedge clk_in);
		end
		chk(16'(seen), 16'h0001);
		chk({13'h0000, mode_out}, {13'h0000, CSW_NORMAL});
		rd_chk(8'h10, 16'h0001);
		wr(8'h10, 16'h0001);
		rd_chk(8'h10, 16'h0000);
		closed <= 3'h0;
	endtask : t_cyclic_sense

	// on-time longer than the period flags an interface failure
	task automatic t_on_too_long;
		wr(8'h04, 16'h0050);
		rd_chk(8'h04, 16'h0050);
		rd_chk(8'h14, 16'h0001);
		wr(8'h04, 16'h0000);
		wr(8'h14, 16'h0001);
		rd_chk(8'h14, 16'h0000);
	endtask : t_on_too_long

	// fail-safe turns a static-on switch off
	task automatic t_fail_safe;
		wr(8'h08, 16'h0001);
		cyc(3);
		chk({13'h0000, highside_switch_out}, 16'h0001);
		fail_safe_in <= 1'b1;
		cyc(4);
		chk({13'h0000, highside_switch_out}, 16'h0000);
		chk({13'h0000, mode_out}, {13'h0000, CSW_FAILSAFE});
	endtask : t_fail_safe

	initial
	begin
		cyc(6);
		rst_b_in <= 1'b1;
		t_reset();
		t_cyclic_wake();
		t_cyclic_sense();
		t_on_too_long();
		t_fail_safe();
		give_verdict();
	end

	initial
	begin
		cyc(90000);
		failures++;
		$display("[ERR] %0t watchdog expired", $time);
		give_verdict();
	end
endmodule : cyclic_sense_wake_timers_bench
